// *** rtl/dpsr_core.sv ***
// burst-of-two dual-port sram: sampled timebases, write port, read port and fifo
//
// Summary of operation
// - dll on: read data after 1.5 cycles
// - dll off: read data after one cycle
// - accesses start only at positive timebase rise
// - write words captured on both timebase rises
// - read data launched on output timebase rises
// - read select low latches read address
// - each access moves two words, one address
// - dll on: first word t+1 negative, second t+2 positive
// - outputs released at next output rise
// - write select low latches first data word
// - negative rise latches address, second word, commits
// - deselected write port finishes pending write first
// - byte lanes sampled per word, masked write
// - output timebase strapped high selects single mode
// - read and write accepted in same cycle
// - read returns newest data for location; with dll off a same-cycle write is not seen
// - selects sampled at positive rise, independent
// - transactions in progress complete on deselect
// - impedance re-tuned every 1024 timebase cycles
// - two free-running echo strobes follow output phases
// - dll locks after 1024 cycles, stop resets
// - reset leaves ports idle, outputs released
// - all lanes high writes nothing

// simple synchronous fifo with valid/ready on both sides
module dpsr_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];                 // entry storage
  logic [AW:0]      wr_ptr;                        // write pointer, wrap bit on top
  logic [AW:0]      rd_ptr;                        // read pointer, wrap bit on top
  logic             push;                          // accepted write
  logic             pop;                           // accepted read

  // full when pointers differ only in wrap bit
  assign in_ready  = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
  assign out_valid = (wr_ptr != rd_ptr);
  assign out_data  = store[rd_ptr[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // pointer update
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

  // entry storage, no reset needed
  always_ff @(posedge ref_clk) begin
    if (push) begin
      store[wr_ptr[AW-1:0]] <= in_data;
    end
  end
endmodule

// device top: memory array and both ports
module dpsr_core
  import dpsr_pkg::*;
#(
  parameter int DATA_W   = 18,                     // word width
  parameter int LANES    = 2,                      // byte lanes per word
  parameter int ADDR_W   = 21,                     // address width, 2M pairs
  parameter int STOP_CYC = DLL_STOP_CYC            // ref_clk cycles of quiet timebase
) (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst,
  // input and output timebases
  input  wire logic              k,
  input  wire logic              k_n,
  input  wire logic              c,
  input  wire logic              c_n,
  // port selects and write lanes
  input  wire logic              read_select_n,
  input  wire logic              write_select_n,
  input  wire logic [LANES-1:0]  byte_lane_write_n,
  // shared address and write data
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] d,
  // dll control
  input  wire logic              dll_disable_n,
  // read data with output enable, low while driving
  output logic      [DATA_W-1:0] q,
  output logic                   q_oe_n,
  // echo strobes
  output logic                   returned_strobe,
  output logic                   returned_strobe_n,
  // status
  output logic                   dll_locked,
  output logic                   impedance_update,
  output logic                   read_ready
);
  localparam int LW = DATA_W / LANES;              // bits per lane
  localparam int SW = 4 + 2 + LANES + ADDR_W + DATA_W;  // synchroniser width

  // two-stage synchroniser for every pin except the dll pin
  logic [SW-1:0] sync_a;                           // first stage, read only by sync_b
  logic [SW-1:0] sync_b;                           // second stage
  logic [3:0]    tb_d;                             // delayed timebases for edge detect

  // synchronised pins
  logic              k_s, kn_s, c_s, cn_s;
  logic              rps_s, wps_s;
  logic [LANES-1:0]  bw_s;
  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] d_s;
  logic              dll_off_s;                    // dll disable pin held low

  // timebase edges
  logic k_rise, kn_rise, c_rise, cn_rise;
  logic out_pos, out_neg;                          // output timebase rises
  logic first_ev, second_ev;                       // word launch events

  // mode state
  logic single_mode;                               // strap captured after reset
  logic strap_done;                                // strap already captured

  // write port state
  logic              wr_pend;                      // first word held
  logic [DATA_W-1:0] wd0;                          // lower word
  logic [LANES-1:0]  wbe0;                         // lower word lanes, active low

  // memory halves
  logic [DATA_W-1:0] mem_lo [2**ADDR_W];           // first word of each pair
  logic [DATA_W-1:0] mem_hi [2**ADDR_W];           // second word of each pair

  // read port state
  logic              rd_pend;                      // read address staged
  logic [ADDR_W-1:0] rd_addr;                      // read address register
  logic              rd_go;                        // read accepted this cycle
  logic              push_ev;                      // fetch and queue event

  // fifo connections
  logic                fifo_in_valid, fifo_in_ready;
  logic                fifo_out_valid, fifo_out_ready;
  logic [2*DATA_W-1:0] fifo_in_data, fifo_out_data;

  // output sequencer
  dpsr_out_e out_state;

  // dll and impedance counters
  logic [10:0] lock_cnt;                           // stable timebase cycles seen
  logic [7:0]  quiet_cnt;                          // ref_clk cycles without k edge
  logic [9:0]  imp_cnt;                            // impedance cadence counter

  // pins through two flip-flops before use
  // no reset here: the chain already holds pin levels when reset lifts,
  // so the strap capture on the first free cycle sees the real c and c_n
  always_ff @(posedge ref_clk) begin
    sync_a <= {k, k_n, c, c_n, read_select_n, write_select_n,
               byte_lane_write_n, addr, d};
    sync_b <= sync_a;
  end

  assign {k_s, kn_s, c_s, cn_s, rps_s, wps_s, bw_s, addr_s, d_s} = sync_b;

  // dll pin is a slow level, its own two stages
  logic dll_a, dll_b;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dll_a <= 1'b0;
      dll_b <= 1'b0;
    end else begin
      dll_a <= dll_disable_n;
      dll_b <= dll_a;
    end
  end
  assign dll_off_s = !dll_b;

  // previous timebase levels for rise detect
  // follows the pins through reset too, so a timebase or strap that is
  // already high at release is not mistaken for a fresh rise
  always_ff @(posedge ref_clk) begin
    tb_d <= {k_s, kn_s, c_s, cn_s};
  end

  assign k_rise  = k_s  && !tb_d[3];
  assign kn_rise = kn_s && !tb_d[2];
  assign c_rise  = c_s  && !tb_d[1];
  assign cn_rise = cn_s && !tb_d[0];

  // single mode times outputs from input pair
  assign out_pos = single_mode ? k_rise  : c_rise;
  assign out_neg = single_mode ? kn_rise : cn_rise;

  // dll on: first word on negative rise; off: on positive rise
  assign first_ev  = dll_off_s ? out_pos : out_neg;
  assign second_ev = dll_off_s ? out_neg : out_pos;

  // strap caught on first cycle after reset release
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      single_mode <= 1'b0;
      strap_done  <= 1'b0;
    end else if (!strap_done) begin
      single_mode <= c_s && cn_s;
      strap_done  <= 1'b1;
    end
  end

  // write port: first word at k rise, address and second word at k_n rise
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_pend <= 1'b0;
      wd0     <= '0;
      wbe0    <= '1;
    end else if (k_rise) begin
      // select sampled only here; both high starts nothing
      wr_pend <= !wps_s;
      wd0     <= d_s;
      wbe0    <= bw_s;
    end else if (kn_rise) begin
      // pending write always finishes, deselect or not
      wr_pend <= 1'b0;
    end
  end

  // array commit of both words with per-lane masking
  always_ff @(posedge ref_clk) begin
    if (kn_rise && wr_pend) begin
      for (int l = 0; l < LANES; l++) begin
        // lane low is written, lane high keeps stored byte
        if (!wbe0[l]) begin
          mem_lo[addr_s][l*LW +: LW] <= wd0[l*LW +: LW];
        end
        if (!bw_s[l]) begin
          mem_hi[addr_s][l*LW +: LW] <= d_s[l*LW +: LW];
        end
      end
    end
  end

  // read accepted at k rise when selected and queue has room
  assign rd_go = k_rise && !rps_s && fifo_in_ready;

  // fetch late enough that earlier writes are visible
  assign push_ev = dll_off_s ? kn_rise : k_rise;

  // read address register and fetch
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_pend <= 1'b0;
      rd_addr <= '0;
    end else if (rd_go) begin
      rd_pend <= 1'b1;
      rd_addr <= addr_s;
    end else if (push_ev) begin
      rd_pend <= 1'b0;
    end
  end

  // array read sees every write committed before this edge
  assign fifo_in_valid = push_ev && rd_pend;
  assign fifo_in_data  = {mem_hi[rd_addr], mem_lo[rd_addr]};

  // read data queue between fetch and output launch
  dpsr_fifo #(
    .WIDTH (2*DATA_W),
    .DEPTH (RD_FIFO_DEPTH)
  ) u_rd_fifo (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // entry leaves queue when its second word goes out
  assign fifo_out_ready = (out_state == OUT_FIRST) && second_ev;

  // output sequencer: word, word, then release
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      out_state <= OUT_IDLE;
      q         <= '0;
      q_oe_n    <= RST_OE_N;
    end else begin
      case (out_state)
        OUT_IDLE: begin
          if (first_ev && fifo_out_valid) begin
            q         <= fifo_out_data[DATA_W-1:0];
            q_oe_n    <= 1'b0;
            out_state <= OUT_FIRST;
          end
        end
        OUT_FIRST: begin
          if (second_ev) begin
            q         <= fifo_out_data[2*DATA_W-1:DATA_W];
            out_state <= OUT_TAIL;
          end
        end
        OUT_TAIL: begin
          if (first_ev && fifo_out_valid) begin
            // next burst follows without a gap
            q         <= fifo_out_data[DATA_W-1:0];
            out_state <= OUT_FIRST;
          end else if (first_ev || second_ev) begin
            q_oe_n    <= 1'b1;
            out_state <= OUT_IDLE;
          end
        end
        default: begin
          out_state <= OUT_IDLE;
        end
      endcase
    end
  end

  // echo strobes follow output phases, or input phases in single mode
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      returned_strobe   <= 1'b0;
      returned_strobe_n <= 1'b0;
    end else begin
      returned_strobe   <= single_mode ? k_s  : c_s;
      returned_strobe_n <= single_mode ? kn_s : cn_s;
    end
  end

  // quiet timebase detector for dll reset
  always_ff @(posedge ref_clk) begin
    if (rst || k_rise || kn_rise) begin
      quiet_cnt <= '0;
    end else if (quiet_cnt != 8'hff) begin
      quiet_cnt <= quiet_cnt + 8'h01;
    end
  end

  // dll lock after stable timebase cycles
  always_ff @(posedge ref_clk) begin
    if (rst || dll_off_s || (quiet_cnt >= STOP_CYC[7:0])) begin
      lock_cnt   <= '0;
      dll_locked <= RST_LOCKED;
    end else if (k_rise) begin
      if (lock_cnt == DLL_LOCK_CYC - 11'h001) begin
        dll_locked <= 1'b1;
      end else begin
        lock_cnt <= lock_cnt + 11'h001;
      end
    end
  end

  // impedance re-tune pulse every 1024 timebase cycles
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      imp_cnt          <= '0;
      impedance_update <= 1'b0;
    end else begin
      impedance_update <= k_rise && (imp_cnt == IMP_LAST_CYC);
      if (k_rise) begin
        imp_cnt <= imp_cnt + 10'h001;
      end
    end
  end

  // queue room shown to the controller side
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      read_ready <= RST_READY;
    end else begin
      read_ready <= fifo_in_ready;
    end
  end
endmodule

// *** rtl/dpsr_pkg.sv ***
// shared constants for the burst-of-two dual-port sram model
package dpsr_pkg;

  // sampling clock
  localparam int CLK_PERIOD_NS = 8;                 // ref_clk period in ns

  // dll lock interval in timebase cycles
  localparam logic [10:0] DLL_LOCK_CYC = 11'h400;   // 1024 cycles

  // dll reset by stopped timebase
  localparam int DLL_STOP_NS  = 30;                 // least stop time in ns
  localparam int DLL_STOP_CYC = (DLL_STOP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // impedance re-tune cadence, 1024 timebase cycles
  localparam logic [9:0] IMP_LAST_CYC = 10'h3ff;    // last count before wrap

  // read data fifo depth
  localparam int RD_FIFO_DEPTH = 32;

  // reset values
  localparam logic RST_OE_N    = 1'b1;              // read outputs released
  localparam logic RST_READY   = 1'b0;              // not ready during reset
  localparam logic RST_LOCKED  = 1'b0;              // dll unlocked

  // read output sequencer states
  typedef enum logic [1:0] {
    OUT_IDLE,                                       // outputs released
    OUT_FIRST,                                      // first word on bus
    OUT_TAIL                                        // second word on bus
  } dpsr_out_e;

endpackage

// *** test/dpsr_core_chk.sv ***
// concurrent checks on the sram top-level pins
module dpsr_core_chk #(
  parameter int DATA_W   = 18,
  parameter int STOP_CYC = 4
) (
  // clock and reset
  input wire logic              ref_clk,
  input wire logic              rst,
  // timebase, select and dll pins
  input wire logic              k,
  input wire logic              k_n,
  input wire logic              read_select_n,
  input wire logic              dll_disable_n,
  // read data and status
  input wire logic [DATA_W-1:0] q,
  input wire logic              q_oe_n,
  input wire logic              returned_strobe,
  input wire logic              returned_strobe_n,
  input wire logic              dll_locked,
  input wire logic              impedance_update,
  input wire logic              read_ready
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  logic [2:0]  ks;    // own k sync chain
  logic [10:0] kcnt;  // k rises since last re-tune pulse
  logic        seen;  // first re-tune pulse seen
  logic [6:0]  qcnt;  // cycles with no k change
  logic [5:0]  rgap;  // cycles since read select low
  logic [2:0]  rcnt;  // cycles since reset release

  // sample k like the device does
  always_ff @(posedge ref_clk) ks <= {ks[1:0], k};
  // count k rises between re-tune pulses
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      kcnt <= '0;
      seen <= 1'b0;
    end else if (impedance_update) begin
      kcnt <= {10'h0, ks[1] & ~ks[2]};
      seen <= 1'b1;
    end else if (ks[1] & ~ks[2]) kcnt <= kcnt + 11'h1;
  end
  // quiet timebase, saturating
  always_ff @(posedge ref_clk) begin
    if (rst || ks[1] != ks[2]) qcnt <= '0;
    else if (qcnt != 7'h7f) qcnt <= qcnt + 7'h1;
  end
  // read select gap, saturating
  always_ff @(posedge ref_clk) begin
    if (rst || !read_select_n) rgap <= '0;
    else if (rgap != 6'h3f) rgap <= rgap + 6'h1;
  end
  // settle time after reset
  always_ff @(posedge ref_clk) begin
    if (rst) rcnt <= '0;
    else if (rcnt != 3'h7) rcnt <= rcnt + 3'h1;
  end

  sequence s_oe_low;
    !q_oe_n [*8];
  endsequence
  sequence s_q_hold;
    $stable(q) [*5];
  endsequence

  property p_rst_idle;
    disable iff (1'b0) rst |=> q_oe_n && !dll_locked && !impedance_update;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("outputs not idle in reset");
  property p_rdy;
    $fell(rst) |-> ##[0:1] read_ready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("read ready late after reset");
  property p_word;
    rcnt == 3'h7 && $changed(q) |=> s_q_hold;
  endproperty
  a_word: assert property (p_word) else $error("read word did not stand");
  property p_burst;
    $fell(q_oe_n) |=> s_oe_low;
  endproperty
  a_burst: assert property (p_burst) else $error("burst shorter than two words");
  property p_idle;
    rgap >= 6'd48 |-> q_oe_n;
  endproperty
  a_idle: assert property (p_idle) else $error("read outputs driven with no read");
  property p_imp;
    impedance_update && seen |-> kcnt inside {[1023:1025]} ##1 !impedance_update;
  endproperty
  a_imp: assert property (p_imp) else $error("re-tune spacing wrong");
  property p_stop;
    qcnt > STOP_CYC + 4 |-> !dll_locked;
  endproperty
  a_stop: assert property (p_stop) else $error("lock kept with stopped timebase");
  property p_dll_off;
    !dll_disable_n [*4] |=> !dll_locked;
  endproperty
  a_dll_off: assert property (p_dll_off) else $error("lock kept with dll off");
  property p_strobe;
    rcnt == 3'h7 |-> returned_strobe == $past(k, 3) && returned_strobe_n == $past(k_n, 3);
  endproperty
  a_strobe: assert property (p_strobe) else $error("echo strobe off its timebase");
endmodule

bind dpsr_core dpsr_core_chk #(.DATA_W(DATA_W), .STOP_CYC(STOP_CYC)) dpsr_core_chk_inst (
  .ref_clk(ref_clk), .rst(rst), .k(k), .k_n(k_n), .read_select_n(read_select_n),
  .dll_disable_n(dll_disable_n), .q(q), .q_oe_n(q_oe_n), .returned_strobe(returned_strobe),
  .returned_strobe_n(returned_strobe_n), .dll_locked(dll_locked),
  .impedance_update(impedance_update), .read_ready(read_ready));

// *** test/dpsr_tb_ctl.sv ***
// controller-side timebase source with single timebase strap
module dpsr_tb_ctl (
  // control
  input  wire logic run,
  // timebases
  output logic      k,
  output logic      k_n,
  output logic      c,
  output logic      c_n
);
  timeunit 1ns;
  timeprecision 100ps;

  // negative timebase is the inverse
  assign k_n = ~k;

  // free-running 125 ns timebase, off ref_clk edges; stop holds it low
  initial begin
    k = 1'b0;
    c = 1'b1;
    c_n = 1'b1;
    #1.3;
    forever begin
      #62.5;
      if (run) k = ~k;
      else k = 1'b0;
    end
  end
endmodule

// *** test/tb_top.sv ***
// self-checking bench for the burst-of-two dual-port sram
module tb_top
  import dpsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        ref_clk = 0, rst = 1, run = 1, dll_disable_n = 1;
  logic        read_select_n = 1, write_select_n = 1;
  logic [1:0]  byte_lane_write_n = '1;
  logic [5:0]  addr = '0;
  logic [17:0] d = '0, q;
  logic        k, k_n, c, c_n, q_oe_n, returned_strobe, returned_strobe_n;
  logic        dll_locked, impedance_update, read_ready;
  int          errors = 0, checks = 0, imp = 0, kcnt = 0, i;
  realtime     t_rd, t_oe;
  logic [17:0] mlo [64], mhi [64]; // expected array halves
  logic [17:0] expq [$], gotq [$]; // expected and seen words

  always #4 ref_clk = ~ref_clk;

  dpsr_tb_ctl dpsr_tb_ctl_inst (.run(run), .k(k), .k_n(k_n), .c(c), .c_n(c_n));
  dpsr_core #(.ADDR_W(6), .STOP_CYC(20)) dpsr_core_inst (
    .ref_clk(ref_clk), .rst(rst), .k(k), .k_n(k_n), .c(c), .c_n(c_n),
    .read_select_n(read_select_n), .write_select_n(write_select_n),
    .byte_lane_write_n(byte_lane_write_n), .addr(addr), .d(d), .dll_disable_n(dll_disable_n),
    .q(q), .q_oe_n(q_oe_n), .returned_strobe(returned_strobe),
    .returned_strobe_n(returned_strobe_n), .dll_locked(dll_locked),
    .impedance_update(impedance_update), .read_ready(read_ready));

  // collect each driven word mid-way after its output rise
  always @(posedge k or posedge k_n) begin
    repeat (6) @(negedge ref_clk);
    if (q_oe_n === 1'b0) gotq.push_back(q);
  end
  // event bookkeeping
  always @(negedge q_oe_n) t_oe = $realtime;
  always @(posedge k) if (!rst) kcnt++;
  always @(posedge ref_clk) if (impedance_update === 1'b1) imp++;

  task chk_val(input logic [17:0] got, input logic [17:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task chk_rng(input realtime v, input realtime lo, input realtime hi);
    checks++;
    if (v < lo || v > hi) begin
      errors++;
      $display("[FAIL] %0t latency %0t out of range", $time, v);
    end
  endtask
  task end_sim;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // byte-lane merge, active low lanes of 9 bits
  function automatic logic [17:0] mrg(input logic [17:0] o, n, input logic [1:0] l);
    mrg = o;
    if (!l[0]) mrg[8:0] = n[8:0];
    if (!l[1]) mrg[17:9] = n[17:9];
  endfunction

  // one timebase cycle: optional read and optional write
  task cyc(input logic rd, input logic [5:0] ra, input logic wr, input logic [5:0] wa,
           input logic [17:0] d0, d1, input logic [1:0] l0, l1);
    @(negedge k);
    repeat (3) @(negedge ref_clk);
    read_select_n = !rd;
    write_select_n = !wr;
    addr = ra;
    d = d0;
    byte_lane_write_n = l0;
    @(posedge k);
    t_rd = $realtime;
    repeat (4) @(negedge ref_clk);
    read_select_n = 1'b1;
    write_select_n = 1'b1;
    addr = wa;
    d = d1;
    byte_lane_write_n = l1;
    if (rd) begin
      expq.push_back(mlo[ra]);
      expq.push_back(mhi[ra]);
    end
    if (wr) begin
      mlo[wa] = mrg(mlo[wa], d0, l0);
      mhi[wa] = mrg(mhi[wa], d1, l1);
    end
  endtask
  // let reads land, then compare word streams
  task drain;
    repeat (60) @(negedge ref_clk);
    chk_val(18'(gotq.size()), 18'(expq.size()));
    while (expq.size() > 0 && gotq.size() > 0) chk_val(gotq.pop_front(), expq.pop_front());
    gotq.delete();
    expq.delete();
  endtask

  initial begin
    repeat (3) @(negedge ref_clk);
    rst = 1'b0;
    // no access before lock
    repeat (1000) @(posedge k);
    chk_val(18'(dll_locked), 18'h0);
    for (i = 0; i < 2000 && dll_locked !== 1'b1; i++) @(negedge ref_clk);
    chk_val(18'(dll_locked), 18'h1);
    if (dll_locked !== 1'b1) end_sim;
    cyc(0, 0, 1, 1, 18'h2a5a5, 18'h15a5a, 2'b00, 2'b00);
    cyc(0, 0, 1, 2, 18'h3ffff, 18'h3ffff, 2'b00, 2'b00);
    cyc(1, 1, 1, 2, 18'h00000, 18'h00000, 2'b10, 2'b01);
    cyc(1, 2, 1, 1, 18'h11111, 18'h22222, 2'b11, 2'b11);
    cyc(1, 1, 0, 0, 18'h0, 18'h0, 2'b11, 2'b11);
    cyc(0, 1, 0, 1, 18'h33333, 18'h0f0f0, 2'b00, 2'b00);
    cyc(1, 1, 0, 0, 18'h0, 18'h0, 2'b11, 2'b11);
    drain;
    cyc(1, 2, 0, 0, 18'h0, 18'h0, 2'b11, 2'b11);
    drain;
    chk_rng(t_oe - t_rd, 180, 240);
    dll_disable_n = 1'b0;
    repeat (10) @(negedge ref_clk);
    chk_val(18'(dll_locked), 18'h0);
    cyc(1, 1, 0, 0, 18'h0, 18'h0, 2'b11, 2'b11);
    drain;
    chk_rng(t_oe - t_rd, 120, 175);
    dll_disable_n = 1'b1;
    for (i = 0; i < 2200 && kcnt < 2100; i++) @(posedge k);
    chk_val(18'(kcnt >= 2100), 18'h1);
    chk_val(18'(imp), 18'h2);
    for (i = 0; i < 8000 && dll_locked !== 1'b1; i++) @(negedge ref_clk);
    chk_val(18'(dll_locked), 18'h1);
    if (dll_locked !== 1'b1) end_sim;
    run = 1'b0;
    repeat (60) @(negedge ref_clk);
    chk_val(18'(dll_locked), 18'h0);
    end_sim;
  end
endmodule
